// ==== exec_pkg.sv ====
// Purpose: constants for the instruction execute subset
// Assumes: 125 MHz core clock, four phases per instruction cycle
// Notes: opcodes, field positions, flag positions and cycle counts
//
// Overview of operation
// - compare-skip-if-less opcode 0110000a, unsigned f minus w, flags untouched
// - when f below w, discard fetched instruction, run no-op, two cycles
// - skip onto two-word instruction makes both words no-ops, three cycles
// - access bit zero addresses access bank, ignores bank select; field 0..255
// - access bit one forms address from bank select and register field
// - destination bit zero writes working register, one writes source register
// - long jump loads 20-bit literal into program counter bits 20..1
// - long jump two words, two cycles, low byte first, pc written phase four
// - increment opcode 001010da, adds one, updates c, dc, n, ov, z
// - register move uses 12-bit addresses, no bank select, no access bank
// - register move two words, two cycles; read first, write last phase
// - register move refuses pc low and stack-top bytes as destination
// - bank-select load 00000001 kkkkkkkk writes literal, one cycle, flags kept
// - rotate left plain 010001da, bit 7 into bit 0, updates n and z
// - rotate right via carry 001100da, bit 0 to carry, carry to bit 7
package exec_pkg;
  localparam logic [5:0] OP_CMP_LT = 6'h18; // 0110 00, then 0a
  localparam logic [6:0] OP_CMP_LT7 = 7'h30;
  localparam logic [3:0] OP_JUMP_W1 = 4'he;
  localparam logic [7:0] OP_JUMP_W1_HI = 8'hef;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;
  localparam logic [5:0] OP_INC = 6'h0a;
  localparam logic [5:0] OP_ROT_L = 6'h11;
  localparam logic [5:0] OP_ROT_RC = 6'h0c;
  localparam logic [3:0] OP_MOVE_W1 = 4'hc;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam int BIT_ACCESS = 8;
  localparam int BIT_DEST = 9;
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [11:0] ADDR_WORKING = 12'hfe8;
  localparam logic [11:0] ADDR_PCL = 12'hff9;
  localparam logic [11:0] ADDR_TOS_LOW = 12'hffd;
  localparam logic [11:0] ADDR_TOS_HIGH = 12'hffe;
  localparam logic [11:0] ADDR_TOS_UPPER = 12'hfff;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [7:0] WORKING_REGISTER_RESET = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam int PHASES = 4;
  typedef enum logic [1:0] {Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b10, Q4 = 2'b11} phase_t;
  typedef enum logic [2:0] {
    S_EXEC = 3'b000, S_FLUSH = 3'b001, S_FLUSH2 = 3'b010, S_JUMP2 = 3'b011, S_MOVE2 = 3'b100
  } exec_state_t;
endpackage

// ==== mem_if.sv ====
// Purpose: data memory port between execute core and its memory
// Assumes: single clock, one read (q2) and one write (q4) per instruction cycle
// Notes: read data registered inside the memory
interface mem_if;
  logic [11:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output rd, output wr, output wdata, input rdata);
  modport mem (input addr, input rd, input wr, input wdata, output rdata);
endinterface

// ==== data_ram.sv ====
// Purpose: 4096 byte banked data memory with registered read
// Assumes: read and write never target the same phase
// Notes: contents are not reset
module data_ram (
  input wire logic clk_i,
  mem_if.mem port
);
  logic [7:0] mem_r [0:4095];
  logic [7:0] rdata_r;
  always_ff @(posedge clk_i)
  begin
    if (port.wr)
    begin
      mem_r[port.addr] <= port.wdata;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (port.rd)
    begin
      rdata_r <= mem_r[port.addr];
    end
  end
  assign port.rdata = rdata_r;
endmodule

// ==== exec_core.sv ====
// Purpose: execute a subset of the 8-bit core instruction set
// Assumes: fetch path presents the next word before each q1; one word per cycle
// Notes: working register is held here and aliased at its data address
module exec_core
  import exec_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fetch path
  input wire logic [15:0] instr_i,
  output logic fetch_o,
  output logic [20:0] pc_o,
  // architectural state
  output logic [7:0] working_o,
  output logic [3:0] bank_select_o,
  output logic [4:0] status_o,
  output logic skip_o,
  output logic illegal_dest_o
);
  mem_if mbus ();
  data_ram u_ram (
    .clk_i(clk_i),
    .port(mbus.mem)
  );

  phase_t phase_r;
  exec_state_t state_r;
  logic [15:0] ir_r;
  logic [11:0] move_src_r;
  logic [7:0] jump_low_r;
  logic [7:0] operand_r;
  logic [7:0] result_r;
  logic [7:0] working_register_r;
  logic [3:0] bank_r;
  logic [4:0] status_r;
  logic [20:0] pc_r;
  logic skip_r;
  logic illegal_r;

  function automatic logic [11:0] reg_addr(input logic acc, input logic [7:0] f, input logic [3:0] bank);
    if (!acc)
      reg_addr = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIGH_BANK, f};
    else
      reg_addr = {bank, f};
  endfunction

  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:12] == OP_MOVE_W1) || (w[15:8] == OP_JUMP_W1_HI);
  endfunction

  logic is_cmp, is_inc, is_rl, is_rrc, is_bank, is_jump, is_move, is_f_op;
  assign is_cmp = (ir_r[15:9] == OP_CMP_LT7);
  assign is_inc = (ir_r[15:10] == OP_INC);
  assign is_rl = (ir_r[15:10] == OP_ROT_L);
  assign is_rrc = (ir_r[15:10] == OP_ROT_RC);
  assign is_bank = (ir_r[15:8] == OP_LOAD_BANK);
  assign is_jump = (ir_r[15:8] == OP_JUMP_W1_HI);
  assign is_move = (ir_r[15:12] == OP_MOVE_W1);
  assign is_f_op = is_cmp | is_inc | is_rl | is_rrc;

  logic [11:0] f_addr;
  logic f_is_w;
  logic [11:0] dst_addr;
  logic dst_bad;
  assign f_addr = reg_addr(ir_r[BIT_ACCESS], ir_r[7:0], bank_r);
  // a move source is a plain 12-bit address, so its bit 8 is no access bit
  assign f_is_w = is_move ? (ir_r[11:0] == ADDR_WORKING) : (f_addr == ADDR_WORKING);
  // the destination word sits in ir_r for the whole second cycle
  assign dst_addr = ir_r[11:0];
  assign dst_bad = (dst_addr == ADDR_PCL) || (dst_addr == ADDR_TOS_LOW) ||
                   (dst_addr == ADDR_TOS_HIGH) || (dst_addr == ADDR_TOS_UPPER);

  ////////////////////////////////////////////////////////////////
  // phase counter and instruction register
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      phase_r <= Q1;
    else
      phase_r <= phase_t'(phase_r + 2'd1);
  end

  // the fetch word is latched at every q4 so it is stable for the whole next cycle;
  // flushed and second-word cycles load too, else the word after them is lost
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ir_r <= 16'h0000;
    else if (phase_r == Q4)
      ir_r <= instr_i;
  end

  ////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_r <= S_EXEC;
    else if (phase_r == Q4)
    begin
      case (state_r)
        S_EXEC:
        begin
          if (is_cmp && skip_r)
            state_r <= two_word(instr_i) ? S_FLUSH2 : S_FLUSH;
          else if (is_jump)
            state_r <= S_JUMP2;
          else if (is_move)
            state_r <= S_MOVE2;
          else
            state_r <= S_EXEC;
        end
        S_FLUSH2: state_r <= S_FLUSH;
        S_FLUSH: state_r <= S_EXEC;
        S_JUMP2: state_r <= S_EXEC;
        S_MOVE2: state_r <= S_EXEC;
        default: state_r <= S_EXEC;
      endcase
    end
  end

  // every cycle latches new instr; a skipped/second word is consumed here
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      fetch_o <= 1'b0;
    else
      fetch_o <= (phase_r == Q3);
  end

  ////////////////////////////////////////////////////////////////
  // operand read q2, latched q3, compute q4
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      operand_r <= 8'h00;
    else if (phase_r == Q3 && state_r == S_EXEC)
      operand_r <= f_is_w ? working_register_r : mbus.rdata;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      move_src_r <= 12'h000;
    else if (phase_r == Q1 && state_r == S_EXEC && is_move)
      move_src_r <= ir_r[11:0];
  end

  logic [8:0] sum;
  logic [7:0] res;
  logic [4:0] fl;
  always_comb
  begin
    sum = {1'b0, operand_r} + 9'h001;
    res = operand_r;
    fl = status_r;
    if (is_inc)
    begin
      res = sum[7:0];
      fl[FLAG_C] = sum[8];
      fl[FLAG_DC] = (operand_r[3:0] == 4'hf);
      fl[FLAG_OV] = (operand_r == 8'h7f);
    end
    else if (is_rl)
      res = {operand_r[6:0], operand_r[7]};
    else if (is_rrc)
    begin
      res = {status_r[FLAG_C], operand_r[7:1]};
      fl[FLAG_C] = operand_r[0];
    end
    fl[FLAG_N] = res[7];
    fl[FLAG_Z] = (res == 8'h00);
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_r <= 8'h00;
    end
    else if (phase_r == Q3 && state_r == S_EXEC)
    begin
      result_r <= f_is_w ? working_register_r : mbus.rdata;
    end
    else if (phase_r == Q4 && state_r == S_EXEC)
    begin
      result_r <= res;
    end
  end

  // unsigned compare, result kept for the skip decision at q4
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      skip_r <= 1'b0;
    else if (phase_r == Q4 && state_r == S_EXEC)
      skip_r <= 1'b0;
    else if (phase_r == Q3 && state_r == S_EXEC && is_cmp)
      skip_r <= ((f_is_w ? working_register_r : mbus.rdata) < working_register_r);
  end
  assign skip_o = skip_r;

  ////////////////////////////////////////////////////////////////
  // memory port: q2 read, q4 write
  logic wr_f, wr_move;
  assign wr_f = (phase_r == Q4) && (state_r == S_EXEC) && (is_inc | is_rl | is_rrc) &&
                ir_r[BIT_DEST] && !f_is_w;
  assign wr_move = (phase_r == Q4) && (state_r == S_MOVE2) && !dst_bad &&
                   (dst_addr != ADDR_WORKING);
  always_comb
  begin
    mbus.rd = (phase_r == Q2) && (state_r == S_EXEC) && (is_f_op | is_move);
    mbus.addr = is_move ? ir_r[11:0] : f_addr;
    mbus.wr = 1'b0;
    mbus.wdata = res;
    if (wr_f)
      mbus.wr = 1'b1;
    else if (wr_move)
    begin
      mbus.wr = 1'b1;
      mbus.addr = dst_addr;
      mbus.wdata = result_r;
    end
    else if (phase_r == Q4)
      mbus.addr = f_addr;
    if (state_r == S_MOVE2 && phase_r != Q4)
      mbus.addr = move_src_r;
  end

  ////////////////////////////////////////////////////////////////
  // architectural registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      working_register_r <= WORKING_REGISTER_RESET;
    else if (phase_r == Q4 && state_r == S_EXEC && (is_inc | is_rl | is_rrc) &&
             (!ir_r[BIT_DEST] || f_is_w))
      working_register_r <= res;
    else if (phase_r == Q4 && state_r == S_MOVE2 && dst_addr == ADDR_WORKING)
      working_register_r <= result_r;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      status_r <= STATUS_RESET;
    else if (phase_r == Q4 && state_r == S_EXEC && (is_inc | is_rl | is_rrc))
      status_r <= fl;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      bank_r <= BANK_RESET;
    else if (phase_r == Q4 && state_r == S_EXEC && is_bank)
      bank_r <= ir_r[3:0];
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      jump_low_r <= 8'h00;
    else if (phase_r == Q2 && state_r == S_EXEC && is_jump)
      jump_low_r <= ir_r[7:0];
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pc_r <= PC_RESET;
    else if (phase_r == Q4 && state_r == S_EXEC && is_jump)
      pc_r <= {instr_i[11:0], jump_low_r, 1'b0};
    else if (phase_r == Q4)
      pc_r <= pc_r + 21'd2;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      illegal_r <= 1'b0;
    else if (phase_r == Q4 && state_r == S_MOVE2)
      illegal_r <= dst_bad;
  end

  assign working_o = working_register_r;
  assign bank_select_o = bank_r;
  assign status_o = status_r;
  assign pc_o = pc_r;
  assign illegal_dest_o = illegal_r;

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_skip_req;
    phase_r == Q4 && state_r == S_EXEC && is_cmp && skip_r;
  endsequence
  property p_flush;
    @(posedge clk_i) disable iff (!resetn_i) s_skip_req |=> state_r != S_EXEC;
  endproperty
  a_flush: assert property (p_flush) else $error("skip did not flush");
  property p_flush2;
    @(posedge clk_i) disable iff (!resetn_i) s_skip_req ##1 state_r == S_FLUSH2 |-> ##4 state_r == S_FLUSH;
  endproperty
  a_flush2: assert property (p_flush2) else $error("two-word skip wrong");
  property p_cmp_flags;
    @(posedge clk_i) disable iff (!resetn_i) (is_cmp || is_bank || is_move) |=> $stable(status_r);
  endproperty
  a_cmp_flags: assert property (p_cmp_flags) else $error("flags changed");
  property p_jump;
    @(posedge clk_i) disable iff (!resetn_i) phase_r == Q4 && state_r == S_EXEC && is_jump |=>
      pc_r[20:1] == {$past(instr_i[11:0]), jump_low_r} ##4 state_r == S_EXEC;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_bank;
    @(posedge clk_i) disable iff (!resetn_i) phase_r == Q4 && state_r == S_EXEC && is_bank |=>
      bank_r == $past(ir_r[3:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not loaded");
  property p_zero;
    @(posedge clk_i) disable iff (!resetn_i) phase_r == Q4 && state_r == S_EXEC && is_inc |=>
      status_r[FLAG_Z] == ($past(operand_r) == 8'hff) &&
      status_r[FLAG_N] == ($past(operand_r) >= 8'h7f && $past(operand_r) != 8'hff);
  endproperty
  a_zero: assert property (p_zero) else $error("zero or negative wrong");
  property p_bad_dest;
    @(posedge clk_i) disable iff (!resetn_i) mbus.wr && state_r == S_MOVE2 |-> !dst_bad;
  endproperty
  a_bad_dest: assert property (p_bad_dest) else $error("forbidden destination written");
  property p_access;
    @(posedge clk_i) disable iff (!resetn_i) is_f_op && !ir_r[BIT_ACCESS] |->
      f_addr[11:8] == (ir_r[7] ? ACCESS_HIGH_BANK : 4'h0);
  endproperty
  a_access: assert property (p_access) else $error("access bank ignored");
endmodule

// ==== prog_feed.sv ====
// Purpose: program word stream standing in for the fetch path
// Assumes: the core takes one word at each fetch pulse, in order
// Notes: between fetches the bus shows the inverted word
module prog_feed (
  // clock and fetch
  input wire logic clk_i,
  input wire logic fetch_i,
  output logic [15:0] instr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words [0:255];
  int wp = 0;
  int rp = 0;
  logic [15:0] head;
  // an empty stream reads as no-op words
  assign head = (rp < wp) ? words[rp[7:0]] : 16'h0000;
  // stale data must never look valid outside a fetch
  assign instr_o = fetch_i ? head : ~head;
  task automatic push(input logic [15:0] w);
    words[wp[7:0]] = w;
    wp++;
  endtask
  always @(posedge clk_i)
  begin
    if (fetch_i && rp < wp)
      rp <= rp + 1;
  end
endmodule

// ==== test_core_instruction_execute_subset.sv ====
// Purpose: self-checking bench for the execute subset
// Assumes: the core samples one word per fetch pulse
// Notes: data memory is seeded by moves from the working register
module test_core_instruction_execute_subset
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] instr_i;
  logic fetch_o, skip_o, illegal_dest_o;
  logic [20:0] pc_o;
  logic [7:0] working_o, w_m;
  logic [3:0] bank_select_o, bank_m;
  logic [4:0] status_o, st_m;
  logic [7:0] mem_m [0:4095];
  int err_total = 0;
  int comparisons = 0;
  int skip_count = 0;
  always #4 clk_i = ~clk_i;
  // the skip flag stands for one clock only, so its pulses are counted
  always @(posedge clk_i)
  begin
    if (skip_o)
      skip_count <= skip_count + 1;
  end
  exec_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr_i), .fetch_o(fetch_o), .pc_o(pc_o),
    .working_o(working_o), .bank_select_o(bank_select_o), .status_o(status_o), .skip_o(skip_o),
    .illegal_dest_o(illegal_dest_o));
  prog_feed prog (.clk_i(clk_i), .fetch_i(fetch_o), .instr_o(instr_i));
  ////////////////////////////////////////
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_state();
    chk("working", 21'(w_m), 21'(working_o));
    chk("bank", 21'(bank_m), 21'(bank_select_o));
    chk("status", 21'(st_m), 21'(status_o));
  endtask
  ////////////////////////////////////////
  function automatic logic [11:0] addr_of(input logic a, input logic [7:0] f);
    if (a)
      return {bank_m, f};
    return {(f < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH_BANK, f};
  endfunction
  function automatic logic [7:0] m_rd(input logic [11:0] ad);
    return (ad == ADDR_WORKING) ? w_m : mem_m[ad];
  endfunction
  task automatic m_wr(input logic [11:0] ad, input logic [7:0] v);
    if (ad == ADDR_WORKING)
      w_m = v;
    else
      mem_m[ad] = v;
  endtask
  // trailing no-op: results land at the edge that fetches it
  task automatic settle();
    int n;
    prog.push(16'h0000);
    n = 0;
    while (prog.rp < prog.wp && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 100)
    begin
      err_total++;
      final_report();
    end
  endtask
  task automatic model_reg(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f);
    logic [11:0] ad;
    logic [7:0] v;
    logic [7:0] r;
    ad = addr_of(a, f);
    v = m_rd(ad);
    if (op == OP_INC)
    begin
      r = v + 8'h01;
      st_m[FLAG_C] = (v == 8'hff);
      st_m[FLAG_DC] = (v[3:0] == 4'hf);
      st_m[FLAG_OV] = (v == 8'h7f);
    end
    else if (op == OP_ROT_L)
      r = {v[6:0], v[7]};
    else
    begin
      r = {st_m[FLAG_C], v[7:1]};
      st_m[FLAG_C] = v[0];
    end
    st_m[FLAG_N] = r[7];
    st_m[FLAG_Z] = (r == 8'h00);
    if (d)
      m_wr(ad, r);
    else
      w_m = r;
  endtask
  task automatic do_reg(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f);
    model_reg(op, d, a, f);
    prog.push({op, d, a, f});
    settle();
    chk_state();
  endtask
  task automatic do_cmp(input logic a, input logic [7:0] f, input logic two);
    logic lt;
    int c0;
    lt = m_rd(addr_of(a, f)) < w_m;
    c0 = skip_count;
    prog.push({OP_CMP_LT7, a, f});
    if (two)
    begin
      prog.push({OP_MOVE_W1, 12'h010});
      prog.push({OP_SECOND_WORD, ADDR_WORKING});
      if (!lt)
        w_m = mem_m[12'h010];
    end
    else
    begin
      prog.push({OP_INC, 1'b1, 1'b0, 8'he8});
      if (!lt)
        model_reg(OP_INC, 1'b1, 1'b0, 8'he8);
    end
    settle();
    chk("skip", 21'(lt), 21'(skip_count - c0));
    chk_state();
  endtask
  task automatic do_move(input logic [11:0] src, input logic [11:0] dst);
    logic bad;
    bad = dst inside {ADDR_PCL, ADDR_TOS_LOW, ADDR_TOS_HIGH, ADDR_TOS_UPPER};
    prog.push({OP_MOVE_W1, src});
    prog.push({OP_SECOND_WORD, dst});
    if (!bad)
      m_wr(dst, m_rd(src));
    settle();
    chk("illegal dest", 21'(bad), 21'(illegal_dest_o));
    chk_state();
  endtask
  task automatic do_bank(input logic [7:0] k);
    prog.push({OP_LOAD_BANK, k});
    bank_m = k[3:0];
    settle();
    chk_state();
  endtask
  // low bits kept clear of a carry so the jump landing can be bounded
  task automatic do_jump(input logic [19:0] k);
    logic [7:0] lo;
    prog.push({OP_JUMP_W1_HI, k[7:0]});
    prog.push({OP_SECOND_WORD, k[19:8]});
    settle();
    lo = pc_o[8:1] - k[7:0];
    chk("jump high", 21'(k[19:8]), 21'(pc_o[20:9]));
    chk("jump low", 21'h1, 21'(lo < 8'h04));
    chk("pc bit0", 21'h0, 21'(pc_o[0]));
  endtask
  function automatic logic [7:0] pick(input logic a, input int unsigned r);
    if (a)
      return 8'h90 + 8'(r % 4);
    return (r % 5 == 4) ? 8'he8 : (r % 5 == 3) ? 8'h85 : 8'h10 + 8'(r % 5);
  endfunction
  ////////////////////////////////////////
  initial
  begin
    int unsigned r;
    logic [11:0] seeds [8] = '{12'h010, 12'h011, 12'h012, 12'hf85, 12'h290, 12'h291, 12'h292, 12'h293};
    logic [11:0] bads [4] = '{ADDR_PCL, ADDR_TOS_LOW, ADDR_TOS_HIGH, ADDR_TOS_UPPER};
    logic [5:0] ops [3] = '{OP_INC, OP_ROT_L, OP_ROT_RC};
    void'($urandom(99));
    w_m = WORKING_REGISTER_RESET;
    bank_m = BANK_RESET;
    st_m = STATUS_RESET;
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    chk("pc", PC_RESET, pc_o);
    chk_state();
    foreach (seeds[i]) do_move(ADDR_WORKING, seeds[i]);
    repeat (4) do_bank(8'($urandom));
    do_bank(8'h02);
    repeat (300) do_reg(OP_INC, 1'b1, 1'b0, 8'he8);
    repeat (60)
    begin
      r = $urandom;
      do_reg(ops[r % 3], r[4], r[5], pick(r[5], r >> 8));
    end
    repeat (24)
    begin
      r = $urandom;
      do_cmp(r[0], pick(r[0], r >> 8), r[1]);
    end
    do_move(12'h290, 12'h7a5);
    do_move(12'h7a5, ADDR_WORKING);
    foreach (bads[i]) do_move(ADDR_WORKING, bads[i]);
    do_move(ADDR_WORKING, 12'h012);
    repeat (3)
    begin
      r = $urandom;
      do_jump({r[19:8], r[7:4], 2'b00, r[1:0]});
    end
    final_report();
  end
endmodule
